// ===== flh_pkg.sv
// Shared constants, types and command sequence table for the flash command controller
package flh_pkg;

    // ==========================================================
    // Widths and clock
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam int CLK_PERIOD_NS = 5;

    // ==========================================================
    // Flash bus cycle timing (host side margins)
    localparam int T_SETUP_NS = 10;
    localparam int T_STROBE_NS = 80;
    localparam int T_HOLD_NS = 20;
    localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Suspend latency the host waits out before touching the array
    localparam int T_ERS_SUSP_NS = 15000;
    localparam int T_PRG_SUSP_NS = 20000;
    localparam int ERS_SUSP_CYC = (T_ERS_SUSP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRG_SUSP_CYC = (T_PRG_SUSP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 13;

    // ==========================================================
    // Register map (byte offsets) and fields
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_OP_W = 4;
    localparam int CTRL_TOGGLE_BIT = 4;
    localparam int CTRL_PRG_BIT = 5;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_FAIL_BIT = 2;
    localparam int STAT_RDY_BIT = 3;

    // ==========================================================
    // Command addresses, data and status bit positions
    localparam logic [ADDR_W-1:0] CA_UNLOCK1 = 22'h00_0555;
    localparam logic [ADDR_W-1:0] CA_UNLOCK2 = 22'h00_0aaa;
    localparam logic [ADDR_W-1:0] CA_PROT_LOCK = 22'h00_0080;
    localparam logic [ADDR_W-1:0] CA_CFI = 22'h00_0055;
    localparam logic [ADDR_W-1:0] CA_LOCKDOWN_OFS = 22'h00_0002;
    localparam logic [ADDR_W-1:0] CA_ANY = 22'h00_0000;
    localparam logic [DATA_W-1:0] CD_AA = 16'h00aa;
    localparam logic [DATA_W-1:0] CD_55 = 16'h0055;
    localparam logic [DATA_W-1:0] CD_ID_ENTRY = 16'h0090;
    localparam logic [DATA_W-1:0] CD_ID_EXIT = 16'h00f0;
    localparam logic [DATA_W-1:0] CD_SUSPEND = 16'h00b0;
    localparam logic [DATA_W-1:0] CD_RESUME = 16'h0030;
    localparam logic [DATA_W-1:0] CD_PROT = 16'h00c0;
    localparam logic [DATA_W-1:0] CD_CFI = 16'h0098;
    localparam logic [DATA_W-1:0] CD_PROT_LOCK = 16'hfffd;
    localparam logic [DATA_W-1:0] CD_NONE = 16'h0000;
    localparam int POLLING_STATUS_BIT = 7;
    localparam int TOGGLE_STATUS_BIT = 6;
    localparam int FAILURE_STATUS_BIT = 5;

    // ==========================================================
    // Operations and sequence steps
    typedef enum logic [3:0] {
        OP_READ = 4'b0000, OP_WRITE = 4'b0001, OP_SUSPEND = 4'b0010, OP_RESUME = 4'b0011,
        OP_ID_EXIT = 4'b0100, OP_CFI_ENTER = 4'b0101, OP_LOCK_QUERY = 4'b0110,
        OP_PROT_LOCK = 4'b0111, OP_PROT_STATUS = 4'b1000, OP_POLL = 4'b1001, OP_PROT_READ = 4'b1010
    } flh_op_type;

    typedef enum logic [1:0] {K_END = 2'b00, K_WR = 2'b01, K_RD = 2'b10, K_WAIT = 2'b11} flh_kind_type;

    typedef struct packed {
        flh_kind_type kind;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } flh_step_type;

    function automatic flh_step_type mk(flh_kind_type k, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        flh_step_type s;
        s.kind = k;
        s.addr = a;
        s.data = d;
        return s;
    endfunction : mk

    // One step of each operation; the unlock pair leads the lock query and the three protection commands
    function automatic flh_step_type seq_step(flh_op_type op, logic [2:0] idx,
                                              logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        flh_step_type s;
        s = mk(K_END, CA_ANY, CD_NONE);
        if (op inside {OP_LOCK_QUERY, OP_PROT_LOCK, OP_PROT_STATUS, OP_PROT_READ} && idx < 3'd2) begin
            s = (idx == 3'd0) ? mk(K_WR, CA_UNLOCK1, CD_AA) : mk(K_WR, CA_UNLOCK2, CD_55);
        end else begin
            unique case (op)
                OP_READ: if (idx == 3'd0) s = mk(K_RD, a, CD_NONE);
                OP_WRITE: if (idx == 3'd0) s = mk(K_WR, a, d);
                OP_SUSPEND: begin
                    if (idx == 3'd0) s = mk(K_WR, CA_ANY, CD_SUSPEND);
                    else if (idx == 3'd1) s = mk(K_WAIT, CA_ANY, CD_NONE);
                end
                OP_RESUME: if (idx == 3'd0) s = mk(K_WR, CA_ANY, CD_RESUME);
                OP_ID_EXIT: if (idx == 3'd0) s = mk(K_WR, CA_ANY, CD_ID_EXIT);
                OP_CFI_ENTER: if (idx == 3'd0) s = mk(K_WR, CA_CFI, CD_CFI);
                OP_POLL: if (idx == 3'd0) s = mk(K_RD, a, CD_NONE);
                OP_PROT_LOCK: begin
                    if (idx == 3'd2) s = mk(K_WR, CA_UNLOCK1, CD_PROT);
                    else if (idx == 3'd3) s = mk(K_WR, CA_PROT_LOCK, CD_PROT_LOCK);
                end
                default: begin
                    if (idx == 3'd2) s = mk(K_WR, CA_UNLOCK1, CD_ID_ENTRY);
                    else if (idx == 3'd3 && op == OP_LOCK_QUERY) s = mk(K_RD, a | CA_LOCKDOWN_OFS, CD_NONE);
                    else if (idx == 3'd3 && op == OP_PROT_STATUS) s = mk(K_RD, CA_PROT_LOCK, CD_NONE);
                    else if (idx == 3'd3 && op == OP_PROT_READ) s = mk(K_RD, a, CD_NONE);
                    else if (idx == 3'd4) s = mk(K_WR, CA_ANY, CD_ID_EXIT);
                end
            endcase
        end
        return s;
    endfunction : seq_step

endpackage : flh_pkg

// ===== flh_wait_timer.sv
// Down-counter that marks the end of a loaded wait
`timescale 1ns/1ps
module flh_wait_timer #(
    parameter int CNT_W = 13
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    input wire logic start,
    input wire logic [CNT_W-1:0] count,
    // Result
    output logic expired
);
    logic [CNT_W-1:0] cnt;
    logic run;

    generate
        if (CNT_W < 2) begin : g_chk
            $error("flh_wait_timer: CNT_W too small");
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= '0;
            run <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= run && cnt == '0;
            if (start) begin
                cnt <= count;
                run <= 1'b1;
            end else if (run && cnt == '0) begin
                run <= 1'b0;
            end else if (run) begin
                cnt <= cnt - 1'b1;
            end
        end
    end
endmodule : flh_wait_timer

// ===== flh_bus_cycle.sv
// One asynchronous flash bus cycle, read or write, on the parallel pins
`timescale 1ns/1ps
module flh_bus_cycle #(
    parameter int AW = 22,
    parameter int DW = 16,
    parameter int SETUP = 2,
    parameter int STROBE = 16,
    parameter int HOLD = 4
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Request
    input wire logic start,
    input wire logic is_write,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    // Answer
    output logic done,
    output logic [DW-1:0] rdata,
    // Flash pins
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [AW-1:0] fa,
    output logic [DW-1:0] dq_out,
    output logic dq_oe_n,
    input wire logic [DW-1:0] dq_in
);
    typedef enum logic [1:0] {C_IDLE = 2'b00, C_SETUP = 2'b01, C_STROBE = 2'b10, C_HOLD = 2'b11} flh_cyc_type;
    flh_cyc_type st;
    logic [7:0] cnt;
    logic wr;
    wire cnt_zero = cnt == 8'h00;

    generate
        if (SETUP < 1 || STROBE < 1 || HOLD < 1 || STROBE > 255 || SETUP > 255 || HOLD > 255) begin : g_chk
            $error("flh_bus_cycle: phase counts out of range");
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= C_IDLE;
            cnt <= 8'h00;
            wr <= 1'b0;
            done <= 1'b0;
            rdata <= '0;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            fa <= '0;
            dq_out <= '0;
            dq_oe_n <= 1'b1;
        end else begin
            done <= 1'b0;
            unique case (st)
                C_IDLE: if (start) begin
                    fa <= addr;
                    dq_out <= wdata;
                    wr <= is_write;
                    dq_oe_n <= ~is_write;
                    ce_n <= 1'b0;
                    cnt <= 8'(SETUP - 1);
                    st <= C_SETUP;
                end
                C_SETUP: if (cnt_zero) begin
                    we_n <= ~wr;
                    oe_n <= wr;
                    cnt <= 8'(STROBE - 1);
                    st <= C_STROBE;
                end else begin
                    cnt <= cnt - 8'h01;
                end
                C_STROBE: if (cnt_zero) begin
                    if (!wr) rdata <= dq_in;
                    we_n <= 1'b1;
                    oe_n <= 1'b1;
                    cnt <= 8'(HOLD - 1);
                    st <= C_HOLD;
                end else begin
                    cnt <= cnt - 8'h01;
                end
                C_HOLD: if (cnt_zero) begin
                    ce_n <= 1'b1;
                    dq_oe_n <= 1'b1;
                    done <= 1'b1;
                    st <= C_IDLE;
                end else begin
                    cnt <= cnt - 8'h01;
                end
            endcase
        end
    end
endmodule : flh_bus_cycle

// ===== flh_ctrl.sv
// Host-side flash command controller with an AHB-Lite register slave
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/1ps
module flh_ctrl (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Flash pins
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic [flh_pkg::ADDR_W-1:0] flash_addr,
    output logic [flh_pkg::DATA_W-1:0] flash_dq_out,
    output logic flash_dq_oe_n,
    input wire logic [flh_pkg::DATA_W-1:0] flash_dq_in,
    input wire logic flash_rdy_busy
);
    localparam int AW = flh_pkg::ADDR_W;
    localparam int DW = flh_pkg::DATA_W;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ISSUE = 3'b001,
        S_WAITCYC = 3'b010,
        S_WAITTMR = 3'b011,
        S_DECIDE = 3'b100
    } flh_state_type;

    // ==========================================================
    // AHB-Lite slave
    logic wr_pend;
    logic [7:0] wr_off;
    wire addr_phase = hsel & htrans[1] & hready;
    wire wr_ctrl = wr_pend & (wr_off == flh_pkg::REG_CTRL);
    wire wr_addr = wr_pend & (wr_off == flh_pkg::REG_ADDR);
    wire wr_wdata = wr_pend & (wr_off == flh_pkg::REG_WDATA);
    wire wr_status = wr_pend & (wr_off == flh_pkg::REG_STATUS);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_off <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend <= addr_phase & hwrite;
            wr_off <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ==========================================================
    // Software registers
    flh_pkg::flh_op_type op;
    logic toggle_mode;
    logic prg_susp;
    logic [AW-1:0] addr_reg;
    logic [DW-1:0] wdata_reg;
    logic [DW-1:0] rdata_reg;
    logic done_flag;
    logic fail_flag;
    logic rdy_q;
    flh_state_type state;
    flh_state_type next_state;

    wire busy = state != S_IDLE;
    wire start_req = wr_ctrl & ~busy;
    wire [flh_pkg::CTRL_OP_W-1:0] op_field = hwdata[flh_pkg::CTRL_OP_LSB +: flh_pkg::CTRL_OP_W];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op <= flh_pkg::OP_READ;
            toggle_mode <= 1'b0;
            prg_susp <= 1'b0;
        end else if (start_req) begin
            op <= flh_pkg::flh_op_type'(op_field);
            toggle_mode <= hwdata[flh_pkg::CTRL_TOGGLE_BIT];
            prg_susp <= hwdata[flh_pkg::CTRL_PRG_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_reg <= '0;
            wdata_reg <= '0;
        end else begin
            if (wr_addr && !busy) addr_reg <= hwdata[AW-1:0];
            if (wr_wdata && !busy) wdata_reg <= hwdata[DW-1:0];
        end
    end

    wire [31:0] status_word = {28'h000_0000, rdy_q, fail_flag, done_flag, busy};
    wire [31:0] ctrl_word = {26'h000_0000, prg_susp, toggle_mode, op};
    wire [7:0] rd_off = haddr[7:0];
    wire [31:0] rd_mux =
        (rd_off == flh_pkg::REG_CTRL) ? ctrl_word :
        (rd_off == flh_pkg::REG_ADDR) ? {{(32 - AW){1'b0}}, addr_reg} :
        (rd_off == flh_pkg::REG_WDATA) ? {{(32 - DW){1'b0}}, wdata_reg} :
        (rd_off == flh_pkg::REG_STATUS) ? status_word :
        (rd_off == flh_pkg::REG_RDATA) ? {{(32 - DW){1'b0}}, rdata_reg} : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

    // ==========================================================
    // Sequencer
    logic [2:0] idx;
    logic [2:0] next_idx;
    logic poll_first;
    logic fail_seen;
    logic [DW-1:0] poll_prev;
    flh_pkg::flh_step_type step;
    logic eng_done;
    logic [DW-1:0] eng_rdata;
    logic tmr_expired;

    assign step = flh_pkg::seq_step(op, idx, addr_reg, wdata_reg);

    wire issue = state == S_ISSUE;
    wire step_end = issue & (step.kind == flh_pkg::K_END);
    wire eng_start = issue & (step.kind == flh_pkg::K_WR || step.kind == flh_pkg::K_RD);
    wire eng_is_write = step.kind == flh_pkg::K_WR;
    wire tmr_start = issue & (step.kind == flh_pkg::K_WAIT);
    wire rd_done = (state == S_WAITCYC) & eng_done & (step.kind == flh_pkg::K_RD);
    wire [flh_pkg::TMR_W-1:0] susp_cnt = prg_susp ?
        flh_pkg::TMR_W'(flh_pkg::PRG_SUSP_CYC - 1) :
        flh_pkg::TMR_W'(flh_pkg::ERS_SUSP_CYC - 1);

    // Poll decision on the latest captured read
    wire data_match = rdata_reg[flh_pkg::POLLING_STATUS_BIT] == wdata_reg[flh_pkg::POLLING_STATUS_BIT];
    wire toggle_stop = !poll_first &&
        (rdata_reg[flh_pkg::TOGGLE_STATUS_BIT] == poll_prev[flh_pkg::TOGGLE_STATUS_BIT]);
    wire poll_ok = toggle_mode ? toggle_stop : data_match;
    wire poll_fail = !poll_ok && fail_seen;
    wire fail_now = rdata_reg[flh_pkg::FAILURE_STATUS_BIT];
    wire decide = state == S_DECIDE;
    wire finish = step_end | (decide & (poll_ok | poll_fail));

    always_comb begin
        next_state = state;
        next_idx = idx;
        unique case (state)
            S_IDLE: begin
                next_idx = 3'd0;
                if (start_req) next_state = S_ISSUE;
            end
            S_ISSUE: begin
                if (step.kind == flh_pkg::K_END) next_state = S_IDLE;
                else if (step.kind == flh_pkg::K_WAIT) next_state = S_WAITTMR;
                else next_state = S_WAITCYC;
            end
            S_WAITCYC: if (eng_done) begin
                if (op == flh_pkg::OP_POLL) begin
                    next_state = S_DECIDE;
                end else begin
                    next_idx = idx + 3'd1;
                    next_state = S_ISSUE;
                end
            end
            S_WAITTMR: if (tmr_expired) begin
                next_idx = idx + 3'd1;
                next_state = S_ISSUE;
            end
            S_DECIDE: begin
                if (poll_ok || poll_fail) next_state = S_IDLE;
                else next_state = S_ISSUE;
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= S_IDLE;
            idx <= 3'd0;
        end else begin
            state <= next_state;
            idx <= next_idx;
        end
    end

    // Read capture and poll history
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_reg <= '0;
            poll_prev <= '0;
        end else if (rd_done) begin
            rdata_reg <= eng_rdata;
            poll_prev <= rdata_reg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            poll_first <= 1'b1;
            fail_seen <= 1'b0;
        end else if (start_req) begin
            poll_first <= 1'b1;
            fail_seen <= 1'b0;
        end else if (decide) begin
            poll_first <= 1'b0;
            fail_seen <= fail_seen | fail_now;
        end
    end

    // Sticky completion flags; a new event wins over a clear in the same cycle
    wire clr_done = wr_status & hwdata[flh_pkg::STAT_DONE_BIT];
    wire clr_fail = wr_status & hwdata[flh_pkg::STAT_FAIL_BIT];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_flag <= 1'b0;
            fail_flag <= 1'b0;
            rdy_q <= 1'b0;
        end else begin
            done_flag <= finish | (done_flag & ~clr_done);
            fail_flag <= (decide & poll_fail) | (fail_flag & ~clr_fail);
            rdy_q <= flash_rdy_busy;
        end
    end

    // ==========================================================
    // Pin cycle engine and suspend wait
    flh_bus_cycle #(
        .AW(AW),
        .DW(DW),
        .SETUP(flh_pkg::SETUP_CYC),
        .STROBE(flh_pkg::STROBE_CYC),
        .HOLD(flh_pkg::HOLD_CYC)
    ) u_cycle (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(eng_start),
        .is_write(eng_is_write),
        .addr(step.addr),
        .wdata(step.data),
        .done(eng_done),
        .rdata(eng_rdata),
        .ce_n(flash_ce_n),
        .oe_n(flash_oe_n),
        .we_n(flash_we_n),
        .fa(flash_addr),
        .dq_out(flash_dq_out),
        .dq_oe_n(flash_dq_oe_n),
        .dq_in(flash_dq_in)
    );

    flh_wait_timer #(
        .CNT_W(flh_pkg::TMR_W)
    ) u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(tmr_start),
        .count(susp_cnt),
        .expired(tmr_expired)
    );

endmodule : flh_ctrl

// ===== flh_ctrl_monitor.sv
// Checker on the flash pin cycles of the command controller
`timescale 1ns/1ps
module flh_ctrl_monitor (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Flash pins
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic [flh_pkg::ADDR_W-1:0] flash_addr,
    input wire logic flash_dq_oe_n
);
    // ==========================================
    // Pin cycle properties
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_excl; !(!flash_oe_n && !flash_we_n); endproperty
    a_excl: assert property (p_excl) else $error("both strobes low");
    property p_wdrv; !flash_we_n |-> !flash_ce_n && !flash_dq_oe_n; endproperty
    a_wdrv: assert property (p_wdrv) else $error("write strobe outside select");
    property p_strobe; $fell(flash_we_n) |-> ##16 $rose(flash_we_n); endproperty
    a_strobe: assert property (p_strobe) else $error("write strobe length");
    property p_cycle; $fell(flash_ce_n) |-> ##22 $rose(flash_ce_n); endproperty
    a_cycle: assert property (p_cycle) else $error("pin cycle length");
    property p_gap; $rose(flash_ce_n) |=> flash_ce_n; endproperty
    a_gap: assert property (p_gap) else $error("select gap too short");
    property p_addr; !flash_ce_n [*2] |-> $stable(flash_addr); endproperty
    a_addr: assert property (p_addr) else $error("address moved in cycle");
    property p_rdir; !flash_oe_n |-> flash_dq_oe_n; endproperty
    a_rdir: assert property (p_rdir) else $error("driving data during read");
    property p_setup; $fell(flash_ce_n) |-> (flash_we_n && flash_oe_n) [*2] ##1 !(flash_we_n && flash_oe_n);
    endproperty
    a_setup: assert property (p_setup) else $error("strobe setup wrong");
    c_wr: cover property ($fell(flash_we_n));
    c_rd: cover property ($fell(flash_oe_n));
    c_two: cover property ($rose(flash_ce_n) ##2 $fell(flash_ce_n));
endmodule : flh_ctrl_monitor

// ===== flh_flash_model.sv
// Behavioural flash device answering the controller's pin cycles
`timescale 1ns/1ps
module flh_flash_model (
    // Flash pins
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [21:0] fa,
    input wire logic [15:0] dq_wire,
    output logic [15:0] dq_drv,
    output logic rdy
);
    // ==========================================
    // Command decode and array
    logic [15:0] mem [256];
    logic [15:0] prev = '0, last = '0, rd;
    logic id_m = 1'b0, cfi_m = 1'b0, st_m = 1'b0, blk_lk = 1'b0, tog = 1'b0;
    realtime t_end = 0, left = 0;
    initial foreach (mem[i]) mem[i] = '0;
    always #1 rdy = $realtime >= t_end;
    always @(negedge oe_n) tog <= ~tog;
    assign rd = st_m ? {8'h00, ~last[7], 2'b01, 5'h00}
        : !rdy ? {8'h00, ~last[7], tog, 6'h00}
        : cfi_m ? 16'h0051
        : id_m && fa[11:0] == 12'h002 ? {15'h0000, fa[12]}
        : id_m && fa[11:0] == 12'h080 ? {14'h0000, !blk_lk, 1'b0}
        : mem[fa[7:0]];
    assign dq_drv = !ce_n && !oe_n ? rd : ~rd;
    always @(posedge we_n) if (!ce_n && oe_n) begin
        if (dq_wire == 16'h00f0) {id_m, cfi_m, st_m} = 3'b000;
        else if (dq_wire == 16'h00b0 && !rdy) begin
            left = t_end - $realtime;
            t_end = 0;
        end else if (dq_wire == 16'h0030) begin
            t_end = $realtime + left;
            left = 0;
        end else if (dq_wire == 16'h0098 && fa[7:0] == 8'h55) cfi_m = 1'b1;
        else if (dq_wire == 16'h0090 && prev == 16'h0055) id_m = 1'b1;
        else if (prev == 16'h00c0) blk_lk = blk_lk | !dq_wire[1];
        else if (dq_wire inside {16'h00aa, 16'h0055, 16'h00c0}) last = last;
        else if (fa[12]) begin
            last = dq_wire;
            st_m = 1'b1;
        end else begin
            last = dq_wire;
            mem[fa[7:0]] = dq_wire;
            t_end = $realtime + 300;
        end
        prev = dq_wire;
    end
endmodule : flh_flash_model

// ===== flh_ctrl_bench.sv
// Self-checking bench for the flash command controller
`timescale 1ns/1ps
module flh_ctrl_bench;
    // ==========================================
    // Signals, design and device
    typedef struct {string nm; logic [31:0] v; logic [31:0] m;} flh_note_type;
    localparam logic [7:0] ST = flh_pkg::REG_STATUS;
    localparam logic [7:0] RD = flh_pkg::REG_RDATA;
    flh_note_type exp_q[$];
    flh_note_type nt;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ck = 1'b0, dp = 1'b0;
    logic [1:0] htrans = '0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rv;
    logic hreadyout, hresp, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe_n, flash_rdy_busy;
    logic [21:0] flash_addr;
    logic [15:0] flash_dq_out, dqm, d, dv [4];
    wire logic [15:0] flash_dq_in = !flash_dq_oe_n ? flash_dq_out : dqm;
    int n_fail = 0, cmp_count = 0;
    flh_ctrl i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hreadyout, .hrdata, .hresp, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr, .flash_dq_out,
        .flash_dq_oe_n, .flash_dq_in, .flash_rdy_busy);
    flh_flash_model i_mem (.ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .fa(flash_addr),
        .dq_wire(flash_dq_in), .dq_drv(dqm), .rdy(flash_rdy_busy));
    initial forever #2.5 hclk = ~hclk;
    // ==========================================
    // Bus tasks and result watcher
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] e);
        cmp_count++;
        if (seen !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, seen);
        end
    endtask : chk
    task automatic bus(logic w, logic [7:0] a, logic [31:0] wd, logic c);
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'b10;
        hsel <= 1'b1;
        ck <= c;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask : bus
    task automatic expect_rd(logic [7:0] a, string nm, logic [15:0] v, logic [15:0] m);
        exp_q.push_back('{nm, {16'h0000, v}, {16'h0000, m}});
        bus(1'b0, a, '0, 1'b1);
    endtask : expect_rd
    task automatic op(logic [5:0] c, logic [21:0] a, logic [15:0] dd);
        bus(1'b1, ST, 32'h0000_0006, 1'b0);
        bus(1'b1, flh_pkg::REG_ADDR, {10'h000, a}, 1'b0);
        bus(1'b1, flh_pkg::REG_WDATA, {16'h0000, dd}, 1'b0);
        bus(1'b1, flh_pkg::REG_CTRL, {26'h000_0000, c}, 1'b0);
        do bus(1'b0, ST, '0, 1'b0); while (rv[1] !== 1'b1);
    endtask : op
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    always @(posedge hclk) begin
        if (dp && hreadyout) begin
            nt = exp_q.pop_front();
            chk(nt.nm, hrdata & nt.m, nt.v);
        end
        dp <= hsel && htrans[1] && !hwrite && ck;
    end
    initial begin
        repeat (60000) @(posedge hclk);
        n_fail++;
        complete_run();
    end
    // ==========================================
    // Tests
    initial begin
        void'($urandom(32'h5bfc));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        expect_rd(ST, "status", 16'h0008, 16'h000f);
        expect_rd(8'h40, "unmapped", 16'h0000, 16'hffff);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            dv[i] = 16'h0100 + 16'($urandom_range(16'hfdff));
            op(6'h01, 22'(i), dv[i]);
            expect_rd(ST, "busy pin", 16'h0000, 16'h0008);
            op({1'b0, i[0], 4'h9}, 22'(i), dv[i]);
            op(6'h00, 22'(i), 16'h0000);
            expect_rd(RD, "data", dv[i], 16'hffff);
        end
        $display("test program done");
        for (int k = 0; k < 2; k++) begin
            d = 16'h0100 + 16'($urandom_range(16'hfdff));
            op(6'h01, 22'h00_0010, d);
            op({k[0], 5'h02}, 22'h00_0010, 16'h0000);
            expect_rd(ST, "suspended", 16'h0008, 16'h0008);
            op(6'h00, 22'h00_0002, 16'h0000);
            expect_rd(RD, "other", dv[2], 16'hffff);
            op(6'h03, 22'h00_0000, 16'h0000);
            op(6'h09, 22'h00_0010, d);
            op(6'h00, 22'h00_0010, 16'h0000);
            expect_rd(RD, "resumed", d, 16'hffff);
        end
        $display("test suspend done");
        op(6'h06, 22'h00_1000, 16'h0000);
        expect_rd(RD, "locked", 16'h0001, 16'h0001);
        op(6'h06, 22'h00_0000, 16'h0000);
        expect_rd(RD, "open", 16'h0000, 16'h0001);
        op(6'h01, 22'h00_1010, 16'h1234);
        op(6'h09, 22'h00_1010, 16'h1234);
        expect_rd(ST, "fail", 16'h0006, 16'h0006);
        op(6'h04, 22'h00_0000, 16'h0000);
        $display("test lockdown done");
        for (int k = 0; k < 2; k++) begin
            op(6'h08, 22'h00_0000, 16'h0000);
            expect_rd(RD, "block lock", k ? 16'h0000 : 16'h0002, 16'h0002);
            op(6'h07, 22'h00_0000, 16'h0000);
        end
        op(6'h0a, 22'h00_0080, 16'h0000);
        expect_rd(RD, "protect read", 16'h0000, 16'h0002);
        op(6'h05, 22'h00_0000, 16'h0000);
        op(6'h00, 22'h00_0001, 16'h0000);
        expect_rd(RD, "query", 16'h0051, 16'hffff);
        op(6'h04, 22'h00_0000, 16'h0000);
        op(6'h00, 22'h00_0001, 16'h0000);
        expect_rd(RD, "array", dv[1], 16'hffff);
        $display("test modes done");
        @(posedge hclk);
        complete_run();
    end
endmodule : flh_ctrl_bench
bind flh_ctrl flh_ctrl_monitor i_mon (.hclk, .hresetn, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr,
    .flash_dq_oe_n);
